// [core/accdse_core.sv]
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module accdse_core
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Instruction issue from the pipeline.
  input wire logic iss_valid,
  input wire logic [accdse_pkg::INSTR_W-1:0] iss_instr,
  input wire logic [accdse_pkg::DATA_W-1:0] iss_rs_data,
  input wire logic [accdse_pkg::DATA_W-1:0] iss_rt_data,
  // Retirement towards the pipeline.
  output logic ret_valid,
  output logic ret_gpr_we,
  output logic [4:0] ret_gpr_idx,
  output logic [accdse_pkg::DATA_W-1:0] ret_gpr_data,
  output logic ret_exc_reserved,
  output logic ret_exc_dsp_off,
  // Avalon-MM register slave.
  input wire logic [accdse_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [accdse_pkg::DATA_W-1:0] avs_writedata,
  output logic [accdse_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest
);
  import accdse_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [ACC_W-1:0] acc [ACC_N];
  logic [DATA_W-1:0] dsp_control_register;
  logic dsp_enable;
  logic [2:0] status;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // The group is recognised only when major code and pool both match.
  wire logic [5:0] f_major = iss_instr[MAJ_HI:MAJ_LO];
  wire logic [5:0] f_pool = iss_instr[POOL_HI:POOL_LO];
  wire logic [7:0] f_sub = iss_instr[SUB_HI:SUB_LO];
  wire logic [1:0] accumulator_select = iss_instr[ASEL_HI:ASEL_LO];
  wire logic [4:0] f_dest = iss_instr[RT_HI:RT_LO];
  wire logic [4:0] f_size = iss_instr[RS_HI:RS_LO];
  wire logic in_group = (f_major == MAJOR_GROUP) && (f_pool == EXT_POOL);
  accdse_op_t op;

  // Sub-opcode selects the operation; anything else is reserved.
  always_comb
  begin
    op = ACCDSE_OP_NONE;
    if (in_group)
    begin
      case (f_sub)
        SUB_DSU_UPPER: op = ACCDSE_OP_DSU_UP;
        SUB_DSU_LOWER: op = ACCDSE_OP_DSU_LO;
        SUB_CROSS: op = ACCDSE_OP_CROSS;
        SUB_EXTRACT: op = ACCDSE_OP_EXT;
        default: op = ACCDSE_OP_NONE;
      endcase
    end
  end

  // Exceptions depend on the encoding and the enable only, never on
  // operand values.
  wire logic known = (op != ACCDSE_OP_NONE);
  wire logic exc_reserved = iss_valid && !known;
  wire logic exc_dsp_off = iss_valid && known && !dsp_enable;
  wire logic exec = iss_valid && known && dsp_enable;
  wire logic is_ext = (op == ACCDSE_OP_EXT);
  wire logic is_dot = known && !is_ext;

  // ****************************************************************
  // Dot products
  // ****************************************************************
  // Operand values are taken as the pipeline presents them.
  wire logic [ACC_W-1:0] acc_sel = acc[accumulator_select];
  // Upper byte lanes.
  wire logic [15:0] pu_hi = iss_rs_data[31:24] * iss_rt_data[31:24];
  wire logic [15:0] pu_lo = iss_rs_data[23:16] * iss_rt_data[23:16];
  wire logic [16:0] sum_up = {1'b0, pu_hi} + {1'b0, pu_lo};
  // Lower byte lanes.
  wire logic [15:0] pl_hi = iss_rs_data[15:8] * iss_rt_data[15:8];
  wire logic [15:0] pl_lo = iss_rs_data[7:0] * iss_rt_data[7:0];
  wire logic [16:0] sum_lo = {1'b0, pl_hi} + {1'b0, pl_lo};
  // Cross halfwords, signed full-width products.
  wire logic signed [31:0] px_b =
    $signed(iss_rs_data[31:16]) * $signed(iss_rt_data[15:0]);
  wire logic signed [31:0] px_a =
    $signed(iss_rs_data[15:0]) * $signed(iss_rt_data[31:16]);
  wire logic [32:0] sum_x = {px_b[31], px_b} + {px_a[31], px_a};
  logic [ACC_W-1:0] dotp;

  // Widen the selected sum: zero for bytes, sign for halfwords.
  always_comb
  begin
    case (op)
      ACCDSE_OP_DSU_UP: dotp = {47'h0, sum_up};
      ACCDSE_OP_DSU_LO: dotp = {47'h0, sum_lo};
      ACCDSE_OP_CROSS: dotp = {{31{sum_x[32]}}, sum_x};
      default: dotp = 64'h0;
    endcase
  end

  // Plain modular subtraction; nothing saturates.
  wire logic [ACC_W-1:0] diff = acc_sel - dotp;
  wire logic acc_wr = exec && is_dot;

  // ****************************************************************
  // Field extract
  // ****************************************************************
  wire logic [5:0] pos = dsp_control_register[POS_HI:POS_LO];
  // Position minus (size+1) >= -1 is the same as position >= size.
  wire logic ext_ok = (pos >= {1'b0, f_size});
  wire logic [5:0] ext_lsb = pos - {1'b0, f_size};
  wire logic [ACC_W-1:0] ext_shift = acc_sel >> ext_lsb;
  wire logic [4:0] ext_gap = 5'd31 - f_size;
  wire logic [31:0] ext_mask = 32'hffff_ffff >> ext_gap;
  // A failed extract returns the same masked value; any value is
  // acceptable there and this avoids a second path.
  wire logic [31:0] ext_field = ext_shift[31:0] & ext_mask;
  wire logic ext_run = exec && is_ext;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic bus_req = avs_read || avs_write;
  wire logic bus_take = bus_req && !avs_waitrequest;
  wire logic bus_wr = avs_write && bus_take;
  wire logic hit_acc = (avs_address <= REG_ACC_LAST);
  wire logic [1:0] bus_acc_idx = avs_address[4:3];
  wire logic bus_lo = avs_address[2];
  wire logic [31:0] be_mask = {{8{avs_byteenable[3]}},
    {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
    {8{avs_byteenable[0]}}};
  wire logic [ACC_W-1:0] bus_acc_sel = acc[bus_acc_idx];
  wire logic [31:0] acc_word = bus_lo ? bus_acc_sel[31:0]
    : bus_acc_sel[63:32];
  wire logic [31:0] acc_merged = (acc_word & ~be_mask)
    | (avs_writedata & be_mask);
  wire logic [31:0] ctl_merged = (dsp_control_register & ~be_mask)
    | (avs_writedata & be_mask);
  wire logic ctl_bus_wr = bus_wr && (avs_address == REG_CTL);
  wire logic cfg_bus_wr = bus_wr && (avs_address == REG_CFG)
    && avs_byteenable[0];
  logic [31:0] rd_mux;

  // Unmapped addresses read zero and swallow writes.
  always_comb
  begin
    rd_mux = 32'h0;
    if (hit_acc)
      rd_mux = acc_word;
    else if (avs_address == REG_CTL)
      rd_mux = dsp_control_register;
    else if (avs_address == REG_CFG)
      rd_mux = {31'h0, dsp_enable};
    else if (avs_address == REG_STAT)
      rd_mux = {29'h0, status};
  end

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One wait cycle gives a registered read path; the access completes
  // on the second edge of every request.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else if (bus_req && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ****************************************************************
  // Accumulators
  // ****************************************************************
  // An executing dot-subtract outranks a bus write to the same
  // accumulator in the same cycle; software must not race the core.
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < ACC_N; i++)
    begin
      if (sys_rst)
        acc[i] <= 64'h0;
      else if (acc_wr && (accumulator_select == i[1:0]))
        acc[i] <= diff;
      else if (bus_wr && hit_acc && (bus_acc_idx == i[1:0]))
        acc[i] <= bus_lo ? {acc[i][63:32], acc_merged}
          : {acc_merged, acc[i][31:0]};
    end
  end

  // ****************************************************************
  // Control, configuration and status
  // ****************************************************************
  // Only the failed flag is touched by the core; position and
  // overflow flags change by software writes alone.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      dsp_control_register <= CTL_RESET;
    else if (ext_run)
      dsp_control_register <= {ctl_bus_wr ? ctl_merged[31:FAIL_BIT+1]
        : dsp_control_register[31:FAIL_BIT+1], !ext_ok,
        ctl_bus_wr ? ctl_merged[FAIL_BIT-1:0]
        : dsp_control_register[FAIL_BIT-1:0]};
    else if (ctl_bus_wr)
      dsp_control_register <= ctl_merged;
  end

  // Enable and sticky-free status of the last retired instruction.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dsp_enable <= CFG_EN_RESET;
      status <= 3'h0;
    end
    else
    begin
      if (cfg_bus_wr)
        dsp_enable <= avs_writedata[CFG_EN_BIT];
      if (iss_valid)
        status <= {ext_run && !ext_ok, exc_dsp_off, exc_reserved};
    end
  end

  // ****************************************************************
  // Retirement
  // ****************************************************************
  // Results retire one cycle after issue; an exception suppresses
  // the register write.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ret_valid <= 1'b0;
      ret_gpr_we <= 1'b0;
      ret_gpr_idx <= 5'h0;
      ret_gpr_data <= 32'h0;
      ret_exc_reserved <= 1'b0;
      ret_exc_dsp_off <= 1'b0;
    end
    else
    begin
      ret_valid <= iss_valid;
      ret_gpr_we <= ext_run;
      ret_gpr_idx <= f_dest;
      ret_gpr_data <= ext_field;
      ret_exc_reserved <= exc_reserved;
      ret_exc_dsp_off <= exc_dsp_off;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Every check rests while reset is asserted. An accumulator is
  // compared with the value sampled at issue, because the select lines
  // may already carry another word one cycle later.
  fail_written_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ext_run |=> dsp_control_register[FAIL_BIT] == !$past(ext_ok))
    else $error("Failed flag not written by extract.");

  pos_kept_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ext_run && !ctl_bus_wr |=> $stable(dsp_control_register[POS_HI:POS_LO]))
    else $error("Extract changed the position field.");

  ouflag_kept_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    acc_wr && !ctl_bus_wr |=> $stable(dsp_control_register[OUF_HI:OUF_LO]))
    else $error("Dot subtract changed overflow flags.");

  dot_result_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    acc_wr |=> acc[$past(accumulator_select)] == $past(diff))
    else $error("Accumulator not updated with difference.");

  ext_acc_kept_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ext_run && !bus_wr |=> acc[$past(accumulator_select)] == $past(acc_sel))
    else $error("Extract modified its accumulator.");

  ext_width_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ext_run |=> ret_gpr_we
      && ((ret_gpr_data >> ($past(f_size) + 6'd1)) == 32'h0))
    else $error("Extract result wider than size plus one.");

  ext_idx_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ext_run |=> ret_gpr_idx == $past(f_dest))
    else $error("Extract wrote the wrong destination.");

  exc_quiet_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    iss_valid && !exec |=> !ret_gpr_we
      && (ret_exc_reserved != ret_exc_dsp_off))
    else $error("Excepting instruction wrote a register.");

  exc_acc_kept_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    iss_valid && !exec && !bus_wr
      |=> acc[$past(accumulator_select)] == $past(acc_sel))
    else $error("Excepting instruction changed an accumulator.");

  exc_ctl_kept_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    iss_valid && !exec && !ctl_bus_wr |=> $stable(dsp_control_register))
    else $error("Excepting instruction changed the control register.");

  reserved_flag_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    iss_valid && !known |=> ret_exc_reserved && !ret_exc_dsp_off)
    else $error("Unknown word not flagged as reserved.");

  dsp_off_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    iss_valid && known && !dsp_enable |=> ret_exc_dsp_off ##1 !ret_gpr_we
      || !$past(iss_valid))
    else $error("Disabled unit executed an instruction.");

  ret_pulse_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    iss_valid |=> ret_valid)
    else $error("Issued word did not retire.");

  bus_wait_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not after one wait cycle.");

endmodule // accdse_core

`default_nettype wire

// [core/accdse_pkg.sv]
package accdse_pkg;

  // ****************************************************************
  // Instruction word layout
  // ****************************************************************
  localparam int unsigned INSTR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ACC_W = 64;
  localparam int unsigned ACC_N = 4;
  localparam int unsigned MAJ_HI = 31;
  localparam int unsigned MAJ_LO = 26;
  localparam int unsigned RT_HI = 25;
  localparam int unsigned RT_LO = 21;
  localparam int unsigned RS_HI = 20;
  localparam int unsigned RS_LO = 16;
  localparam int unsigned ASEL_HI = 15;
  localparam int unsigned ASEL_LO = 14;
  localparam int unsigned SUB_HI = 13;
  localparam int unsigned SUB_LO = 6;
  localparam int unsigned POOL_HI = 5;
  localparam int unsigned POOL_LO = 0;

  // Opcode values of the handled group.
  localparam logic [5:0] MAJOR_GROUP = 6'h00;
  localparam logic [5:0] EXT_POOL = 6'h3c;
  localparam logic [7:0] SUB_DSU_UPPER = 8'h92;
  localparam logic [7:0] SUB_DSU_LOWER = 8'hd2;
  localparam logic [7:0] SUB_CROSS = 8'h52;
  localparam logic [7:0] SUB_EXTRACT = 8'h99;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned POS_HI = 5;
  localparam int unsigned POS_LO = 0;
  localparam int unsigned FAIL_BIT = 14;
  localparam int unsigned OUF_HI = 19;
  localparam int unsigned OUF_LO = 16;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] REG_ACC_BASE = 6'h00;
  localparam logic [5:0] REG_ACC_LAST = 6'h1c;
  localparam logic [5:0] REG_CTL = 6'h20;
  localparam logic [5:0] REG_CFG = 6'h24;
  localparam logic [5:0] REG_STAT = 6'h28;
  localparam int unsigned CFG_EN_BIT = 0;
  localparam logic CFG_EN_RESET = 1'b1;
  localparam int unsigned STAT_RI_BIT = 0;
  localparam int unsigned STAT_DIS_BIT = 1;
  localparam int unsigned STAT_FAIL_BIT = 2;

  // Decoded operation kinds.
  typedef enum logic [2:0] {
    ACCDSE_OP_NONE,
    ACCDSE_OP_DSU_UP,
    ACCDSE_OP_DSU_LO,
    ACCDSE_OP_CROSS,
    ACCDSE_OP_EXT
  } accdse_op_t;

endpackage

// [verification/accdse_pipe_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Issuing pipeline model
// ****************************************************************
module accdse_pipe_model
(
  // Clock.
  input wire logic clk_sys,
  // Issue towards the core.
  output logic iss_valid,
  output logic [accdse_pkg::INSTR_W-1:0] iss_instr,
  output logic [accdse_pkg::DATA_W-1:0] iss_rs_data,
  output logic [accdse_pkg::DATA_W-1:0] iss_rt_data
);
  import accdse_pkg::*;

  // Idle at time zero with no word on offer.
  initial
  begin
    iss_valid = 1'b0;
    iss_instr = 32'h0000_0000;
    iss_rs_data = 32'h0000_0000;
    iss_rt_data = 32'h0000_0000;
  end

  // One word for one edge; afterwards the lines show the inverse so a
  // core that samples late cannot pass on a stale copy.
  task automatic issue(input logic [31:0] w, input logic [31:0] s,
                       input logic [31:0] t);
    @(posedge clk_sys);
    iss_valid <= 1'b1;
    iss_instr <= w;
    iss_rs_data <= s;
    iss_rt_data <= t;
    @(posedge clk_sys);
    iss_valid <= 1'b0;
    iss_instr <= ~w;
    iss_rs_data <= ~s;
    iss_rt_data <= ~t;
  endtask
endmodule // accdse_pipe_model

`default_nettype wire

// [verification/tb_accum_dot_subtract_extract.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_accum_dot_subtract_extract;
  import accdse_pkg::*;

  // ****************************************************************
  // Harness
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic iss_valid, ret_valid, ret_gpr_we, ret_exc_reserved, ret_exc_dsp_off;
  logic [31:0] iss_instr, iss_rs_data, iss_rt_data, ret_gpr_data, q;
  logic [4:0] ret_gpr_idx;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic avs_waitrequest;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic [63:0] acc_m [4];
  logic [7:0] sub_tab [3] = '{8'h92, 8'hd2, 8'h52};
  int pos_tab [6] = '{63, 40, 5, 4, 0, 0};
  int len_tab [6] = '{31, 0, 5, 5, 0, 1};
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  // Free-running system clock.
  always #50 clk_sys = ~clk_sys;

  accdse_core uut
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .iss_valid(iss_valid),
    .iss_instr(iss_instr), .iss_rs_data(iss_rs_data),
    .iss_rt_data(iss_rt_data), .ret_valid(ret_valid),
    .ret_gpr_we(ret_gpr_we), .ret_gpr_idx(ret_gpr_idx),
    .ret_gpr_data(ret_gpr_data), .ret_exc_reserved(ret_exc_reserved),
    .ret_exc_dsp_off(ret_exc_dsp_off), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  accdse_pipe_model pipe
  (
    .clk_sys(clk_sys), .iss_valid(iss_valid), .iss_instr(iss_instr),
    .iss_rs_data(iss_rs_data), .iss_rt_data(iss_rt_data)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge,
  // takes read data there and releases; only the timeout ends a hang.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check({32'h0000_0000, q}, {32'h0000_0000, e});
  endtask

  // Retirement pulse is looked at in the cycle after the taking edge.
  task automatic op(input logic [31:0] w, input logic [31:0] s,
                    input logic [31:0] t);
    pipe.issue(w, s, t);
    @(negedge clk_sys);
  endtask

  function automatic logic [31:0] ins(input logic [7:0] sub,
    input logic [1:0] asel, input logic [4:0] f1, input logic [4:0] f2);
    return {6'h00, f1, f2, asel, sub, 6'h3c};
  endfunction

  // Expected accumulator after a dot-subtract of kind k.
  function automatic logic [63:0] dsub(input int k, input logic [63:0] a,
    input logic [31:0] s, input logic [31:0] t);
    logic [63:0] d;
    if (k == 0)
      d = 64'(s[31:24]) * 64'(t[31:24]) + 64'(s[23:16]) * 64'(t[23:16]);
    else if (k == 1)
      d = 64'(s[15:8]) * 64'(t[15:8]) + 64'(s[7:0]) * 64'(t[7:0]);
    else
      d = 64'($signed(s[31:16])) * 64'($signed(t[15:0]))
        + 64'($signed(s[15:0])) * 64'($signed(t[31:16]));
    return a - d;
  endfunction

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      report_and_stop;
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    logic [63:0] a;
    logic [31:0] s, t, c;
    logic f;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(6'h00, 32'h0000_0000);
    rd(6'h20, 32'h0000_0000);
    rd(6'h24, 32'h0000_0001);
    rd(6'h2c, 32'h0000_0000);
    bus(1'b1, 6'h20, 32'h000a_0000);
    // Every kind on every accumulator, with a borrow across the halves for both byte kinds.
    for (int sel = 0; sel < 4; sel++)
      for (int k = 0; k < 3; k++)
      begin
        s = 32'hff80_7f01 + 32'(sel);
        t = 32'h80ff_01fe - 32'(k);
        a = {32'h0000_0001 + 32'(sel), 32'h0000_0010 + 32'(k)};
        bus(1'b1, 6'(8 * sel), a[63:32]);
        bus(1'b1, 6'(8 * sel + 4), a[31:0]);
        acc_m[sel] = dsub(k, a, s, t);
        op(ins(sub_tab[k], 2'(sel), 5'd3, 5'd4), s, t);
        check({ret_valid, ret_gpr_we, ret_exc_reserved, ret_exc_dsp_off},
              4'b1000);
        rd(6'(8 * sel), acc_m[sel][63:32]);
        rd(6'(8 * sel + 4), acc_m[sel][31:0]);
        rd(6'h20, 32'h000a_0000);
      end
    // Field extracts at the edges of the valid range.
    a = 64'hf0e1_d2c3_b4a5_9687;
    bus(1'b1, 6'h10, a[63:32]);
    bus(1'b1, 6'h14, a[31:0]);
    for (int i = 0; i < 6; i++)
    begin
      f = pos_tab[i] < len_tab[i];
      c = 32'h000a_0000 | 32'(pos_tab[i]);
      bus(1'b1, 6'h20, c | (f ? 32'h0 : 32'h4000));
      op(ins(8'h99, 2'd2, 5'd5, 5'(len_tab[i])), 32'h0, 32'h0);
      check({ret_valid, ret_gpr_we, ret_gpr_idx}, {2'b11, 5'd5});
      if (!f)
        check(ret_gpr_data, (a >> (pos_tab[i] - len_tab[i]))
          & ((64'h1 << (len_tab[i] + 1)) - 1));
      rd(6'h20, c | (f ? 32'h4000 : 32'h0));
      rd(6'h28, f ? 32'h0000_0004 : 32'h0000_0000);
      rd(6'h10, a[63:32]);
      rd(6'h14, a[31:0]);
    end
    // Refused words leave accumulators and control alone; only status records them.
    op(ins(8'h00, 2'd1, 5'd3, 5'd4), 32'hffff_ffff, 32'hffff_ffff);
    check({ret_exc_reserved, ret_exc_dsp_off, ret_gpr_we}, 3'b100);
    rd(6'h28, 32'h0000_0001);
    bus(1'b1, 6'h24, 32'h0000_0000);
    op(ins(8'h92, 2'd1, 5'd3, 5'd4), 32'hffff_ffff, 32'hffff_ffff);
    check({ret_exc_reserved, ret_exc_dsp_off, ret_gpr_we}, 3'b010);
    rd(6'h08, acc_m[1][63:32]);
    rd(6'h0c, acc_m[1][31:0]);
    op(ins(8'h99, 2'd2, 5'd5, 5'd0), 32'h0, 32'h0);
    check({ret_exc_reserved, ret_exc_dsp_off, ret_gpr_we}, 3'b010);
    rd(6'h28, 32'h0000_0002);
    rd(6'h20, 32'h000a_4000);
    bus(1'b1, 6'h24, 32'h0000_0001);
    rd(6'h24, 32'h0000_0001);
    report_and_stop;
  end
endmodule // tb_accum_dot_subtract_extract

`default_nettype wire
